// ### rtl/gdfp_top.sv
// Fault protection logic for a three phase gate driver
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// [RULE_01] Supply or drain-sense lockout: gates off, charge pump off, fault low.
// [RULE_02] Supply lockout latches fault and flag, recovers gates on its own.
// [RULE_03] Supply flag stays until clear-faults or enable reset pulse.
// [RULE_04] Gate-rail undervoltage: gates off, fault low, charge pump kept.
// [RULE_05] Gate-rail undervoltage latches flags, recovers automatically.
// [RULE_06] Gate-rail flag sticky; disable bit honoured only in serial variant.
// [RULE_07] Overcurrent counts only on a conducting FET beyond deglitch time.
// [RULE_08] Pin variant: 4 us deglitch, 8 ms retry, trip pin tie disables.
// [RULE_09] Serial variant: trip, deglitch and two-bit response from registers.
// [RULE_10] Cycle-by-cycle: PWM rising edge clears overcurrent; software may disable.
// [RULE_11] Scope 0 stops own half-bridge, scope 1 stops all three.
// [RULE_12] Latched mode: stop, fault low, flags until condition gone and clear.
// [RULE_13] Retry mode: stop, fault low, flags and stop until retry time ends.
// [RULE_14] Report mode: fault low and flags only, gates keep running.
// [RULE_15] Disabled mode: overcurrent gives no action and no report.
// [RULE_16] Amplifier drain sense forces low-side reference to negative shunt.
// [RULE_17] Controller must handle overcurrent itself in report mode.
// [RULE_18] Fault output low while any reported fault is active or latched.
module gdfp_top #(
  parameter int unsigned RETRY_CYCLES = gdfp_pkg::RETRY_CYC
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog comparator results, asynchronous
  input  wire logic        supply_uv_in,
  input  wire logic        drain_sense_supply_uv_in,
  input  wire logic        charge_pump_rail_uv_in,
  input  wire logic        lowside_gate_rail_uv_in,
  input  wire logic [5:0]  drain_source_overcurrent_in,
  // Controller pins and straps, asynchronous
  input  wire logic [5:0]  pwm_in,
  input  wire logic        enable_in,
  input  wire logic        trip_level_pin_at_logic,
  input  wire logic        pin_variant_strap,
  // Gate and analog controls
  output logic [5:0]       gate_on,
  output logic             charge_pump_en,
  output logic [3:0]       overcurrent_trip_level,
  output logic             lowside_ref_shunt_neg,
  // Open-drain fault pin and interrupt
  output logic             fault_out_n_o,
  output logic             fault_out_n_oe,
  output logic             irq
);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RT_IDLE,
    RT_COUNT
  } gdfp_retry_type;

  logic [gdfp_pkg::SY_W-1:0]   sync1_reg;
  logic [gdfp_pkg::SY_W-1:0]   sync2_reg;
  logic [5:0]                  pwm_prev_reg;
  logic                        en_prev_reg;
  logic [gdfp_pkg::CTRL_W-1:0] ctrl_reg;
  logic [gdfp_pkg::IRQ_W-1:0]  irq_stat_reg;
  logic [gdfp_pkg::IRQ_W-1:0]  irq_mask_reg;
  logic                        suv_flag_reg;
  logic                        guv_flag_reg;
  logic                        fault_flag_reg;
  logic [5:0]                  oc_flag_reg;
  logic                        clr_pulse_reg;
  logic                        fault_low_reg;
  logic [31:0]                 retry_cnt_reg;
  gdfp_retry_type              retry_state_reg;
  logic                        bvalid_reg;
  logic                        rvalid_reg;
  logic [1:0]                  bresp_reg;
  logic [31:0]                 rdata_reg;
  logic [1:0]                  rresp_reg;

  logic                        hw_mode;
  logic                        supply_uv;
  logic                        gate_uv;
  logic                        enable_s;
  logic [5:0]                  oc_s;
  logic [5:0]                  pwm_s;
  logic [1:0]                  resp_sel;
  logic [gdfp_pkg::DEG_W-1:0]  deg_limit;
  logic [5:0]                  oc_evt;
  logic                        clr_any;
  logic                        cbc_clr;
  logic                        retry_done;
  logic [2:0]                  bridge_stop;
  logic                        fault_cond;
  logic                        wr_go;
  logic                        rd_go;
  logic [31:0]                 wmask;
  logic [gdfp_pkg::IRQ_W-1:0]  irq_evt;
  logic [31:0]                 stat_word;

  // Two-stage synchroniser for every pin input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {pwm_in, drain_source_overcurrent_in,
                    pin_variant_strap, trip_level_pin_at_logic, enable_in,
                    lowside_gate_rail_uv_in, charge_pump_rail_uv_in,
                    drain_sense_supply_uv_in, supply_uv_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign hw_mode   = sync2_reg[gdfp_pkg::SY_HW];
  assign enable_s  = sync2_reg[gdfp_pkg::SY_EN];
  assign oc_s      = sync2_reg[gdfp_pkg::SY_OC +: 6];
  assign pwm_s     = sync2_reg[gdfp_pkg::SY_PWM +: 6];
  assign supply_uv = sync2_reg[gdfp_pkg::SY_SUV] |
                     sync2_reg[gdfp_pkg::SY_DUV];
  // Disable bit ignored in the pin variant
  assign gate_uv = (sync2_reg[gdfp_pkg::SY_CPUV] |
                    sync2_reg[gdfp_pkg::SY_GLUV]) &
                   (hw_mode | !ctrl_reg[gdfp_pkg::GUV_DIS_BIT]); // [RULE_06]

  // Response and deglitch selection per variant
  always_comb begin
    if (hw_mode) begin
      resp_sel  = sync2_reg[gdfp_pkg::SY_TRIPDIS] ?
                  gdfp_pkg::RESP_OFF : gdfp_pkg::RESP_RETRY; // [RULE_08]
      deg_limit = gdfp_pkg::HW_DEG_CYC; // [RULE_08]
    end else begin
      resp_sel = ctrl_reg[gdfp_pkg::RESP_LSB +: 2]; // [RULE_09]
      case (ctrl_reg[gdfp_pkg::DEG_LSB +: 2]) // [RULE_09]
        2'h0:    deg_limit = gdfp_pkg::DEG0_CYC;
        2'h1:    deg_limit = gdfp_pkg::DEG1_CYC;
        2'h2:    deg_limit = gdfp_pkg::DEG2_CYC;
        default: deg_limit = gdfp_pkg::DEG3_CYC;
      endcase
    end
  end

  // Per FET deglitch counter
  generate
    for (genvar i = 0; i < gdfp_pkg::NFET; i++) begin : g_deg
      logic [gdfp_pkg::DEG_W-1:0] cnt_reg;
      logic                       hot;
      assign hot = oc_s[i] & gate_on[i]; // [RULE_07]
      assign oc_evt[i] = hot && (cnt_reg >= deg_limit) &&
                         (resp_sel != gdfp_pkg::RESP_OFF); // [RULE_15]
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_reg <= '0;
        end else if (!hot) begin
          cnt_reg <= '0;
        end else if (cnt_reg < deg_limit) begin
          cnt_reg <= cnt_reg + 1'b1; // [RULE_07]
        end
      end
    end
  endgenerate

  // Clear command: register bit or enable rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_prev_reg   <= 1'b0;
      pwm_prev_reg  <= '0;
      clr_pulse_reg <= 1'b0;
    end else begin
      en_prev_reg   <= enable_s;
      pwm_prev_reg  <= pwm_s;
      clr_pulse_reg <= wr_go && (s_axi_awaddr == gdfp_pkg::CTRL_OFS) &&
                       s_axi_wstrb[0] && s_axi_wdata[gdfp_pkg::CLR_BIT];
    end
  end

  assign clr_any = clr_pulse_reg | (enable_s & !en_prev_reg);
  assign cbc_clr = |(pwm_s & ~pwm_prev_reg) &&
                   (hw_mode || !ctrl_reg[gdfp_pkg::CBC_DIS_BIT]); // [RULE_10]

  // Retry timer
  assign retry_done = (retry_state_reg == RT_COUNT) &&
                      (retry_cnt_reg == RETRY_CYCLES - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retry_state_reg <= RT_IDLE;
      retry_cnt_reg   <= '0;
    end else begin
      case (retry_state_reg)
        RT_IDLE: begin
          if (|oc_evt && resp_sel == gdfp_pkg::RESP_RETRY) begin
            retry_state_reg <= RT_COUNT; // [RULE_13]
            retry_cnt_reg   <= '0;
          end
        end
        RT_COUNT: begin
          if (|oc_evt) begin
            retry_cnt_reg <= '0;
          end else if (retry_done || oc_flag_reg == '0) begin
            retry_state_reg <= RT_IDLE;
            retry_cnt_reg   <= '0;
          end else begin
            retry_cnt_reg <= retry_cnt_reg + 32'h00000001;
          end
        end
        default: retry_state_reg <= RT_IDLE;
      endcase
    end
  end

  // Overcurrent flags, set wins over every clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_flag_reg <= '0;
    end else begin
      for (int i = 0; i < gdfp_pkg::NFET; i++) begin
        if (oc_evt[i]) begin
          oc_flag_reg[i] <= 1'b1; // [RULE_12] [RULE_14]
        end else if (cbc_clr || retry_done) begin
          oc_flag_reg[i] <= 1'b0; // [RULE_10] [RULE_13]
        end else if (clr_any && !oc_s[i]) begin
          oc_flag_reg[i] <= 1'b0; // [RULE_12] [RULE_14]
        end
      end
    end
  end

  // Undervoltage and general flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      suv_flag_reg   <= 1'b0;
      guv_flag_reg   <= 1'b0;
      fault_flag_reg <= 1'b0;
    end else begin
      if (supply_uv) begin
        suv_flag_reg <= 1'b1; // [RULE_02]
      end else if (clr_any) begin
        suv_flag_reg <= 1'b0; // [RULE_03]
      end
      if (gate_uv) begin
        guv_flag_reg <= 1'b1; // [RULE_05]
      end else if (clr_any) begin
        guv_flag_reg <= 1'b0; // [RULE_06]
      end
      if (supply_uv || gate_uv || |oc_evt) begin
        fault_flag_reg <= 1'b1; // [RULE_02] [RULE_05] [RULE_12]
      end else if (clr_any || (retry_done && !suv_flag_reg &&
                               !guv_flag_reg)) begin
        fault_flag_reg <= 1'b0;
      end
    end
  end

  // Half-bridge stop from overcurrent
  always_comb begin
    bridge_stop = '0;
    if (resp_sel == gdfp_pkg::RESP_LATCH ||
        resp_sel == gdfp_pkg::RESP_RETRY) begin
      for (int b = 0; b < 3; b++) begin
        bridge_stop[b] = oc_flag_reg[2*b] | oc_flag_reg[2*b+1]; // [RULE_11]
      end
      if (ctrl_reg[gdfp_pkg::SCOPE_BIT] && !hw_mode && |oc_flag_reg) begin
        bridge_stop = 3'h7; // [RULE_11]
      end
    end
  end

  assign fault_cond = supply_uv | gate_uv |
                      ((resp_sel != gdfp_pkg::RESP_OFF) &
                       (|oc_flag_reg)); // [RULE_18]

  // Gate, charge pump and analog controls
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_on               <= '0;
      charge_pump_en        <= 1'b0;
      fault_low_reg         <= 1'b0;
      overcurrent_trip_level <= '0;
      lowside_ref_shunt_neg <= 1'b0;
    end else begin
      for (int i = 0; i < gdfp_pkg::NFET; i++) begin
        gate_on[i] <= pwm_s[i] & enable_s & !supply_uv & !gate_uv &
                      !bridge_stop[i/2]; // [RULE_01] [RULE_04] [RULE_12]
      end
      charge_pump_en <= !supply_uv; // [RULE_01] [RULE_04]
      fault_low_reg  <= fault_cond; // [RULE_01] [RULE_18]
      overcurrent_trip_level <= ctrl_reg[gdfp_pkg::TRIP_LSB +: 4];
      lowside_ref_shunt_neg <= ctrl_reg[gdfp_pkg::AMP_DS_BIT] |
                               ctrl_reg[gdfp_pkg::LSREF_BIT]; // [RULE_16]
    end
  end

  assign fault_out_n_o  = 1'b0;
  assign fault_out_n_oe = fault_low_reg;

  // AXI4-Lite slave, address and data taken together
  assign wr_go = s_axi_awvalid & s_axi_wvalid & !bvalid_reg;
  assign rd_go = s_axi_arvalid & !rvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      wmask[8*k +: 8] = {8{s_axi_wstrb[k]}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= gdfp_pkg::CTRL_RESET;
      irq_mask_reg <= gdfp_pkg::IRQ_RESET;
    end else if (wr_go) begin
      if (s_axi_awaddr == gdfp_pkg::CTRL_OFS) begin
        ctrl_reg <= (ctrl_reg & ~(wmask[gdfp_pkg::CTRL_W-1:0] &
                                  gdfp_pkg::CTRL_WMASK)) |
                    (s_axi_wdata[gdfp_pkg::CTRL_W-1:0] &
                     wmask[gdfp_pkg::CTRL_W-1:0] & gdfp_pkg::CTRL_WMASK);
      end
      if (s_axi_awaddr == gdfp_pkg::IRQ_MASK_OFS && s_axi_wstrb[0]) begin
        irq_mask_reg <= s_axi_wdata[gdfp_pkg::IRQ_W-1:0];
      end
    end
  end

  // Sticky event bits, write one to clear
  assign irq_evt = {|oc_evt, gate_uv & !guv_flag_reg,
                    supply_uv & !suv_flag_reg};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= gdfp_pkg::IRQ_RESET;
    end else if (wr_go && s_axi_awaddr == gdfp_pkg::IRQ_STAT_OFS &&
                 s_axi_wstrb[0]) begin
      irq_stat_reg <= irq_evt |
                      (irq_stat_reg & ~s_axi_wdata[gdfp_pkg::IRQ_W-1:0]);
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_evt;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_comb begin
    stat_word = '0;
    stat_word[gdfp_pkg::ST_FAULT] = fault_flag_reg;
    stat_word[gdfp_pkg::ST_SUV]   = suv_flag_reg;
    stat_word[gdfp_pkg::ST_GUV]   = guv_flag_reg;
    stat_word[gdfp_pkg::ST_OC]    = |oc_flag_reg;
    stat_word[gdfp_pkg::ST_FET_LSB +: 6] = oc_flag_reg;
    stat_word[gdfp_pkg::ST_PIN]   = fault_low_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (s_axi_awaddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= RESP_OKAY;
        case (s_axi_araddr)
          gdfp_pkg::CTRL_OFS:     rdata_reg <= 32'(ctrl_reg);
          gdfp_pkg::STAT_OFS:     rdata_reg <= stat_word;
          gdfp_pkg::IRQ_STAT_OFS: rdata_reg <= 32'(irq_stat_reg);
          gdfp_pkg::IRQ_MASK_OFS: rdata_reg <= 32'(irq_mask_reg);
          default: begin
            rdata_reg <= '0;
            rresp_reg <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Checks
  a_uv_gates_off: assert property (@(posedge aclk) disable iff (!aresetn)
    supply_uv |=> (gate_on == '0) && !charge_pump_en && fault_low_reg)
    else $error("supply lockout did not stop gates"); // [RULE_01]
  a_suv_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    suv_flag_reg && !clr_any |=> suv_flag_reg)
    else $error("supply flag lost without clear"); // [RULE_03]
  a_guv_keep_cp: assert property (@(posedge aclk) disable iff (!aresetn)
    gate_uv && !supply_uv |=> (gate_on == '0) && charge_pump_en)
    else $error("gate rail undervoltage response wrong"); // [RULE_04]
  a_guv_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    gate_uv |=> guv_flag_reg && fault_flag_reg)
    else $error("gate rail flags not latched"); // [RULE_05]
  a_oc_on_fet: assert property (@(posedge aclk) disable iff (!aresetn)
    |oc_evt |-> |(oc_s & gate_on) && $past(oc_s & gate_on, 1) != '0)
    else $error("overcurrent on idle FET"); // [RULE_07]
  a_report_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    resp_sel == gdfp_pkg::RESP_REPORT && enable_s && !supply_uv &&
    !gate_uv |=> gate_on == $past(pwm_s))
    else $error("report mode stopped a bridge"); // [RULE_14]
  a_off_silent: assert property (@(posedge aclk) disable iff (!aresetn)
    resp_sel == gdfp_pkg::RESP_OFF && oc_flag_reg == '0 |=>
    oc_flag_reg == '0 || $past(resp_sel, 1) != resp_sel)
    else $error("disabled mode raised a flag"); // [RULE_15]
  a_linked_all: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[gdfp_pkg::SCOPE_BIT] && !hw_mode && |oc_flag_reg &&
    resp_sel == gdfp_pkg::RESP_LATCH |=> gate_on == '0)
    else $error("linked scope missed a bridge"); // [RULE_11]
  a_retry_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    retry_done && !(|oc_evt) |=> oc_flag_reg == '0)
    else $error("retry expiry kept flags"); // [RULE_13]
  a_lsref_force: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[gdfp_pkg::AMP_DS_BIT] |=> lowside_ref_shunt_neg)
    else $error("low-side reference not forced"); // [RULE_16]
  a_fault_release: assert property (@(posedge aclk) disable iff (!aresetn)
    !fault_cond |=> !fault_out_n_oe)
    else $error("fault pin held without cause"); // [RULE_18]

endmodule : gdfp_top

// ### rtl/gdfp_pkg.sv
// Constants for the gate driver fault protection block
package gdfp_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFS = 4'hC;
  // Control field positions
  localparam int CLR_BIT = 0;
  localparam int GUV_DIS_BIT = 1;
  localparam int RESP_LSB = 2;
  localparam int SCOPE_BIT = 4;
  localparam int DEG_LSB = 5;
  localparam int CBC_DIS_BIT = 7;
  localparam int AMP_DS_BIT = 8;
  localparam int LSREF_BIT = 9;
  localparam int TRIP_LSB = 10;
  localparam int CTRL_W = 14;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 14'h3FFE;
  // Status field positions
  localparam int ST_FAULT = 0;
  localparam int ST_SUV = 1;
  localparam int ST_GUV = 2;
  localparam int ST_OC = 3;
  localparam int ST_FET_LSB = 4;
  localparam int ST_PIN = 10;
  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int EV_SUV = 0;
  localparam int EV_GUV = 1;
  localparam int EV_OC = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  // Overcurrent responses
  localparam logic [1:0] RESP_LATCH = 2'h0;
  localparam logic [1:0] RESP_RETRY = 2'h1;
  localparam logic [1:0] RESP_REPORT = 2'h2;
  localparam logic [1:0] RESP_OFF = 2'h3;
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int DEG0_NS = 1000;
  localparam int DEG1_NS = 2000;
  localparam int DEG2_NS = 4000;
  localparam int DEG3_NS = 8000;
  localparam int HW_DEG_NS = 4000;
  localparam int RETRY_MS = 8;
  localparam int DEG_W = 12;
  localparam logic [DEG_W-1:0] DEG0_CYC =
    DEG_W'((DEG0_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [DEG_W-1:0] DEG1_CYC =
    DEG_W'((DEG1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [DEG_W-1:0] DEG2_CYC =
    DEG_W'((DEG2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [DEG_W-1:0] DEG3_CYC =
    DEG_W'((DEG3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [DEG_W-1:0] HW_DEG_CYC =
    DEG_W'((HW_DEG_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam longint RETRY_CYC_L =
    (longint'(RETRY_MS) * 64'd1000000000) / CLK_PERIOD_PS;
  localparam int unsigned RETRY_CYC = 32'(RETRY_CYC_L);
  // Pin sync bus layout
  localparam int SY_SUV = 0;
  localparam int SY_DUV = 1;
  localparam int SY_CPUV = 2;
  localparam int SY_GLUV = 3;
  localparam int SY_EN = 4;
  localparam int SY_TRIPDIS = 5;
  localparam int SY_HW = 6;
  localparam int SY_OC = 7;
  localparam int SY_PWM = 13;
  localparam int SY_W = 19;
  localparam int NFET = 6;
endpackage : gdfp_pkg

// ### dv/gdfp_ctrl_model.sv
// Motor controller model: PWM source and pulled-up fault line
`timescale 1ns/1ps
module gdfp_ctrl_model (
  // Clock
  input  wire logic       aclk,
  // Bench commands
  input  wire logic [5:0] pwm_cmd,
  input  wire logic       oc_guard,
  // Device side
  input  wire logic       fault_o,
  input  wire logic       fault_oe,
  output logic [5:0]      pwm_out,
  output wire logic       fault_line
);
  assign fault_line = fault_oe ? fault_o : 1'b1;
  initial pwm_out = 6'h00;
  // Stops switching itself when the device only reports
  always @(posedge aclk) begin
    pwm_out <= (oc_guard && !fault_line) ? 6'h00 : pwm_cmd;
  end
endmodule // gdfp_ctrl_model

// ### dv/tb.sv
// Self-checking bench for the fault protection block
`timescale 1ns/1ps
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, smp, guard;
  logic        suv, duv, cpuv, gluv, en, cp_en, lsref, f_oe, f_o, f_line;
  logic        irq, hw, tpin;
  logic [3:0]  awaddr, araddr, wstrb, trip_o;
  logic [31:0] wdata, rdata, lfsr;
  logic [1:0]  bresp, rresp;
  logic [5:0]  oc, pwm_cmd, pwm, gate_on;
  logic [4:0]  x_ctl;
  logic [31:0] rq[$];
  logic [13:0] pq[$];
  logic [1:0]  rsq[$];
  int          miscompares, n_checks, cyc;
  localparam logic [3:0] CT = gdfp_pkg::CTRL_OFS;
  localparam logic [3:0] ST = gdfp_pkg::STAT_OFS;
  gdfp_top #(.RETRY_CYCLES(50)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .supply_uv_in(suv),
    .drain_sense_supply_uv_in(duv), .charge_pump_rail_uv_in(cpuv),
    .lowside_gate_rail_uv_in(gluv), .drain_source_overcurrent_in(oc),
    .pwm_in(pwm), .enable_in(en), .trip_level_pin_at_logic(tpin),
    .pin_variant_strap(hw), .gate_on(gate_on), .charge_pump_en(cp_en),
    .overcurrent_trip_level(trip_o), .lowside_ref_shunt_neg(lsref),
    .fault_out_n_o(f_o), .fault_out_n_oe(f_oe), .irq(irq));
  gdfp_ctrl_model ctl (.aclk(aclk), .pwm_cmd(pwm_cmd), .oc_guard(guard),
    .fault_o(f_o), .fault_oe(f_oe), .pwm_out(pwm), .fault_line(f_line));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge aclk); while (!bvalid);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    rsq.push_back({a[1:0] != 2'h0, 1'b0});
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask
  task automatic pins(input logic [5:0] g, input logic c, f, i);
    pq.push_back({x_ctl, i, f, c, g});
    smp <= 1'b1;
    tick(1);
    smp <= 1'b0;
    tick(1);
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Result watcher: oldest note against each read and pin result, OKAY against each write response
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (rvalid && rready) chk("rdata", rdata, rq.pop_front());
    if (rvalid && rready) chk("rresp", 32'(rresp), 32'(rsq.pop_front()));
    if (bvalid && bready) chk("bresp", 32'(bresp), 32'h0);
    if (smp) chk("pins", 32'({lsref, trip_o, irq, f_line, cp_en, gate_on}),
                 32'(pq.pop_front()));
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, smp, guard} = 6'h00;
    {bready, rready, en, wstrb} = 7'h7F;
    {suv, duv, cpuv, gluv, oc, pwm_cmd, x_ctl, hw, tpin} = 23'h0;
    {awaddr, araddr, wdata, cyc} = '0;
    lfsr = 32'h000015D0;
    tick(4);
    aresetn <= 1'b1;
    tick(4);
    rd(CT, 32'h0);
    rd(4'h2, 32'h0);
    lfsr = xs(lfsr);
    x_ctl = {1'b1, lfsr[3:0]};
    wr(CT, {18'h0, lfsr[3:0], 10'h301});
    rd(CT, {18'h0, lfsr[3:0], 10'h300});
    wr(CT, {18'h0, x_ctl[3:0], 10'h100});
    pins(6'h00, 1'b1, 1'b1, 1'b0);
    x_ctl[4] = 1'b0;
    wr(CT, {18'h0, x_ctl[3:0], 10'h000});
    pins(6'h00, 1'b1, 1'b1, 1'b0);
    for (int j = 0; j < 2; j++) begin
      pwm_cmd <= 6'h15;
      if (j == 0) suv <= 1'b1;
      else duv <= 1'b1;
      tick(6);
      pins(6'h00, 1'b0, 1'b0, 1'b0);
      {suv, duv} <= 2'b00;
      tick(8);
      pins(6'h15, 1'b1, 1'b1, 1'b0);
      rd(ST, 32'h3);
      wr(CT, {18'h0, x_ctl[3:0], 10'h001});
      rd(ST, 32'h0);
    end
    wr(gdfp_pkg::IRQ_MASK_OFS, 32'h7);
    pins(6'h15, 1'b1, 1'b1, 1'b1);
    wr(gdfp_pkg::IRQ_STAT_OFS, 32'h7);
    pins(6'h15, 1'b1, 1'b1, 1'b0);
    cpuv <= 1'b1;
    tick(6);
    pins(6'h00, 1'b1, 1'b0, 1'b1);
    cpuv <= 1'b0;
    tick(6);
    pins(6'h15, 1'b1, 1'b1, 1'b1);
    rd(ST, 32'h5);
    en <= 1'b0;
    tick(6);
    en <= 1'b1;
    tick(6);
    rd(ST, 32'h0);
    wr(gdfp_pkg::IRQ_STAT_OFS, 32'h7);
    wr(CT, {18'h0, x_ctl[3:0], 10'h002});
    gluv <= 1'b1;
    tick(6);
    pins(6'h15, 1'b1, 1'b1, 1'b0);
    gluv <= 1'b0;
    wr(gdfp_pkg::IRQ_MASK_OFS, 32'h0);
    for (int i = 0; i < 5; i++) begin
      lfsr = xs(lfsr);
      x_ctl = {1'b0, lfsr[3:0]};
      wr(CT, {18'h0, lfsr[3:0], 2'h0, i == 0, 2'h0, i == 4, i[1:0], 2'h0});
      pwm_cmd <= 6'h05;
      oc <= 6'h03;
      tick(100);
      oc <= 6'h02;
      tick(5);
      pins(6'h05, 1'b1, 1'b1, 1'b0);
      oc <= 6'h03;
      tick(215);
      pins(i[1] ? 6'h05 : (i == 4 ? 6'h00 : 6'h04), 1'b1, i == 3, 1'b0);
      if (i == 0) rd(ST, 32'h419);
      if (i == 1) begin
        tick(45);
        pins(6'h05, 1'b1, 1'b1, 1'b0);
      end
      if (i == 2) begin
        guard <= 1'b1;
        tick(6);
        pins(6'h00, 1'b1, 1'b0, 1'b0);
        guard <= 1'b0;
      end
      oc <= 6'h00;
      pwm_cmd <= 6'h00;
      tick(6);
      pwm_cmd <= 6'h05;
      tick(6);
      pins(i == 0 ? 6'h04 : 6'h05, 1'b1, i != 0, 1'b0);
      if (i == 0) begin
        wr(CT, {18'h0, x_ctl[3:0], 10'h001});
        tick(2);
        pins(6'h05, 1'b1, 1'b1, 1'b0);
      end
    end
    hw <= 1'b1;
    oc <= 6'h03;
    tick(700);
    pins(6'h05, 1'b1, 1'b1, 1'b0);
    tick(110);
    pins(6'h04, 1'b1, 1'b0, 1'b0);
    tpin <= 1'b1;
    tick(900);
    pins(6'h05, 1'b1, 1'b1, 1'b0);
    results();
  end
endmodule // tb
